// ==== rtl/adcc_defs.vh ====
// Constants of the converter control block: offsets, fields and timing.
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH
`define ADCC_AW 5
`define ADCC_OFS_GEN 5'h00
`define ADCC_OFS_ACC 5'h01
`define ADCC_OFS_REFP 5'h02
`define ADCC_OFS_DLY 5'h03
`define ADCC_OFS_WMODE 5'h04
`define ADCC_OFS_SLEN 5'h05
`define ADCC_OFS_INSEL 5'h06
`define ADCC_OFS_CMD 5'h08
`define ADCC_OFS_EVT 5'h09
`define ADCC_OFS_IEN 5'h0a
`define ADCC_OFS_IFLG 5'h0b
`define ADCC_OFS_DBG 5'h0c
`define ADCC_OFS_SCR 5'h0d
`define ADCC_OFS_RES_L 5'h10
`define ADCC_OFS_RES_H 5'h11
`define ADCC_OFS_WLO_L 5'h12
`define ADCC_OFS_WLO_H 5'h13
`define ADCC_OFS_WHI_L 5'h14
`define ADCC_OFS_WHI_H 5'h15
`define ADCC_OFS_TRIM 5'h16
`define ADCC_GEN_ENABLE 0
`define ADCC_GEN_CONT 1
`define ADCC_GEN_RES8 2
`define ADCC_GEN_SBRUN 7
`define ADCC_GEN_MASK 8'h87
`define ADCC_REFP_MASK 8'h77
`define ADCC_FLG_RDY 0
`define ADCC_FLG_WIN 1
`define ADCC_WM_NONE 3'h0
`define ADCC_WM_BELOW 3'h1
`define ADCC_WM_ABOVE 3'h2
`define ADCC_WM_INSIDE 3'h3
`define ADCC_WM_OUTSIDE 3'h4
`define ADCC_ACC_MAX 3'h6
`define ADCC_DLY_MAX 3'h5
`define ADCC_DLY_BASE 9'h010
`define ADCC_CONV_BASE 7'h0d
`define ADCC_RESET_BYTE 8'h00
`endif

// ==== rtl/adcc_ctrl.v ====
// Control, event, interrupt and sleep logic of a 10-bit converter.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`include "adcc_defs.vh"

module adcc_ctrl #(
    parameter DW = 8,
    parameter SW = 10
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [`ADCC_AW-1:0] addr,
    input wire [DW-1:0] wdata,
    input wire wr,
    input wire rd,
    output reg [DW-1:0] rdata,
    input wire start_evt,
    output reg result_ready_evt,
    output wire irq,
    input wire standby_sleep,
    input wire powerdown_sleep,
    input wire debug_halt,
    output wire peripheral_clock_req,
    input wire [SW-1:0] sample_data,
    output wire sampling,
    output wire [4:0] input_sel,
    output wire [DW-1:0] ref_prescale,
    output wire trim_bit,
    output reg result_invalid
);

    localparam ST_IDLE = 3'b001;
    localparam ST_INIT = 3'b010;
    localparam ST_CONV = 3'b100;

    reg [7:0] general_control;
    reg [2:0] accumulation_control;
    reg [7:0] reference_prescale_control;
    reg [7:0] delay_control;
    reg [2:0] window_mode_control;
    reg [4:0] sample_length_control;
    reg [4:0] input_select;
    reg conversion_start;
    reg event_start_enable;
    reg [1:0] interrupt_enable;
    reg [1:0] interrupt_flags;
    reg debug_keep_running;
    reg [7:0] scratch_byte;
    reg [15:0] converted_value;
    reg [15:0] window_low_threshold;
    reg [15:0] window_high_threshold;
    reg duty_cycle_trim;

    reg [2:0] state;
    reg [7:0] presc_cnt;
    reg [8:0] cyc_cnt;
    reg [6:0] samp_idx;
    reg [15:0] acc;
    reg evt_prev;
    reg was_active;
    reg frozen_mid;

    wire enable = general_control[`ADCC_GEN_ENABLE];
    wire continuous_conversion = general_control[`ADCC_GEN_CONT];
    wire res8 = general_control[`ADCC_GEN_RES8];
    wire standby_run = general_control[`ADCC_GEN_SBRUN];
    wire [2:0] initial_delay = delay_control[7:5];
    wire sdv_en = delay_control[4];
    wire [3:0] samp_dly = delay_control[3:0];
    wire [2:0] presc = reference_prescale_control[2:0];

    // Standby without the run bit and power-down both stop the converter.
    wire dbg_stop = debug_halt & ~debug_keep_running;
    wire active = enable & ~powerdown_sleep & ~dbg_stop &
        (~standby_sleep | standby_run);

    wire [8:0] presc_top9 = (9'h002 << presc) - 9'h001;
    wire [7:0] presc_top = presc_top9[7:0];
    wire tick = active & (presc_cnt == presc_top);

    // Prescaled converter cycles.
    wire [8:0] init_len = (initial_delay == 3'h0 ||
        initial_delay > `ADCC_DLY_MAX) ? 9'h000 :
        (`ADCC_DLY_BASE << (initial_delay - 3'h1));
    wire [6:0] conv_len = `ADCC_CONV_BASE + {3'h0, samp_dly} +
        {2'h0, sample_length_control};
    wire [2:0] acc_sel = (accumulation_control > `ADCC_ACC_MAX) ?
        3'h0 : accumulation_control;
    wire [6:0] samp_last = (7'h01 << acc_sel) - 7'h01;

    wire samp_done = (state == ST_CONV) & tick &
        (cyc_cnt == {2'h0, conv_len} - 9'h001);
    wire final_samp = samp_done & (samp_idx == samp_last);

    wire [9:0] samp_val = res8 ? {2'h0, sample_data[SW-1:SW-8]} :
        sample_data[9:0];
    wire [15:0] total = acc + {6'h00, samp_val};

    reg win_hit;
    always @* begin
        case (window_mode_control)
            `ADCC_WM_BELOW: win_hit = total < window_low_threshold;
            `ADCC_WM_ABOVE: win_hit = total > window_high_threshold;
            `ADCC_WM_INSIDE: win_hit = (total > window_low_threshold) &&
                (total < window_high_threshold);
            `ADCC_WM_OUTSIDE: win_hit = (total < window_low_threshold) ||
                (total > window_high_threshold);
            default: win_hit = 1'b0;
        endcase
    end

    wire evt_rise = start_evt & ~evt_prev;
    wire evt_start = evt_rise & event_start_enable & enable;
    wire sw_start = wr & (addr == `ADCC_OFS_CMD) & wdata[0];
    // Continuous mode keeps the start bit, so the next sample follows.
    wire clr_start = final_samp & ~continuous_conversion;
    wire set_rdy = final_samp;
    wire set_win = final_samp & win_hit;
    wire flg_wr = wr & (addr == `ADCC_OFS_IFLG);

    assign irq = |(interrupt_enable & interrupt_flags);
    // In standby the clock is held across a conversion and across the start-up delay.
    assign peripheral_clock_req = standby_sleep & active &
        (state != ST_IDLE);
    assign sampling = (state == ST_CONV);
    assign input_sel = input_select;
    assign ref_prescale = reference_prescale_control;
    assign trim_bit = duty_cycle_trim;

    always @(posedge clk) begin
        if (rst) begin
            general_control <= `ADCC_RESET_BYTE;
            accumulation_control <= 3'h0;
            reference_prescale_control <= `ADCC_RESET_BYTE;
            window_mode_control <= `ADCC_WM_NONE;
            sample_length_control <= 5'h00;
            input_select <= 5'h00;
            event_start_enable <= 1'b0;
            interrupt_enable <= 2'h0;
            debug_keep_running <= 1'b0;
            scratch_byte <= `ADCC_RESET_BYTE;
            window_low_threshold <= 16'h0000;
            window_high_threshold <= 16'h0000;
            duty_cycle_trim <= 1'b0;
        end else if (ce && wr) begin
            case (addr)
                `ADCC_OFS_GEN: general_control <= wdata & `ADCC_GEN_MASK;
                `ADCC_OFS_ACC: accumulation_control <= wdata[2:0];
                `ADCC_OFS_REFP:
                    reference_prescale_control <= wdata & `ADCC_REFP_MASK;
                `ADCC_OFS_WMODE: window_mode_control <= wdata[2:0];
                `ADCC_OFS_SLEN: sample_length_control <= wdata[4:0];
                `ADCC_OFS_INSEL: input_select <= wdata[4:0];
                `ADCC_OFS_EVT: event_start_enable <= wdata[0];
                `ADCC_OFS_IEN: interrupt_enable <= wdata[1:0];
                `ADCC_OFS_DBG: debug_keep_running <= wdata[0];
                `ADCC_OFS_SCR: scratch_byte <= wdata;
                `ADCC_OFS_WLO_L: window_low_threshold[7:0] <= wdata;
                `ADCC_OFS_WLO_H: window_low_threshold[15:8] <= wdata;
                `ADCC_OFS_WHI_L: window_high_threshold[7:0] <= wdata;
                `ADCC_OFS_WHI_H: window_high_threshold[15:8] <= wdata;
                `ADCC_OFS_TRIM: duty_cycle_trim <= wdata[0];
                default: ;
            endcase
        end
    end

    // Sampling delay is shared by software writes and hardware stepping.
    always @(posedge clk) begin
        if (rst) begin
            delay_control <= `ADCC_RESET_BYTE;
        end else if (ce) begin
            if (wr && addr == `ADCC_OFS_DLY) begin
                delay_control <= wdata;
            end else if (samp_done && sdv_en) begin
                delay_control[3:0] <= samp_dly + 4'h1;
            end
        end
    end

    // Set wins over clear for the start bit and for both flags.
    always @(posedge clk) begin
        if (rst) begin
            conversion_start <= 1'b0;
            interrupt_flags <= 2'h0;
            evt_prev <= 1'b0;
        end else if (ce) begin
            evt_prev <= start_evt;
            if (sw_start || evt_start) begin
                conversion_start <= 1'b1;
            end else if (clr_start || !enable) begin
                conversion_start <= 1'b0;
            end else if (wr && addr == `ADCC_OFS_CMD) begin
                conversion_start <= wdata[0];
            end
            interrupt_flags[`ADCC_FLG_RDY] <= set_rdy |
                (interrupt_flags[`ADCC_FLG_RDY] &
                ~(flg_wr & wdata[`ADCC_FLG_RDY]));
            interrupt_flags[`ADCC_FLG_WIN] <= set_win |
                (interrupt_flags[`ADCC_FLG_WIN] &
                ~(flg_wr & wdata[`ADCC_FLG_WIN]));
        end
    end

    // The prescaler only runs while the converter is active.
    always @(posedge clk) begin
        if (rst) begin
            presc_cnt <= 8'h00;
        end else if (ce) begin
            if (!active || presc_cnt == presc_top) begin
                presc_cnt <= 8'h00;
            end else begin
                presc_cnt <= presc_cnt + 8'h01;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            cyc_cnt <= 9'h000;
            samp_idx <= 7'h00;
            acc <= 16'h0000;
            was_active <= 1'b0;
            frozen_mid <= 1'b0;
            converted_value <= 16'h0000;
            result_invalid <= 1'b0;
            result_ready_evt <= 1'b0;
        end else if (ce) begin
            was_active <= active;
            result_ready_evt <= set_rdy & enable;
            if (powerdown_sleep && state == ST_CONV) begin
                frozen_mid <= 1'b1;
            end
            if (!enable) begin
                state <= ST_IDLE;
                frozen_mid <= 1'b0;
            end else if (active) begin
                // Frozen while enabled but inactive; resumes where it stopped.
                case (state)
                    ST_IDLE: begin
                        if (!was_active && init_len != 9'h000) begin
                            state <= ST_INIT;
                            cyc_cnt <= 9'h000;
                        end else if (conversion_start && tick) begin
                            state <= ST_CONV;
                            cyc_cnt <= 9'h000;
                            samp_idx <= 7'h00;
                            acc <= 16'h0000;
                        end
                    end
                    ST_INIT: begin
                        if (tick) begin
                            if (cyc_cnt == init_len - 9'h001) begin
                                state <= ST_IDLE;
                            end else begin
                                cyc_cnt <= cyc_cnt + 9'h001;
                            end
                        end
                    end
                    ST_CONV: begin
                        if (final_samp) begin
                            converted_value <= total;
                            result_invalid <= frozen_mid;
                            frozen_mid <= 1'b0;
                            acc <= 16'h0000;
                            samp_idx <= 7'h00;
                            cyc_cnt <= 9'h000;
                            if (!continuous_conversion) begin
                                state <= ST_IDLE;
                            end
                        end else if (samp_done) begin
                            acc <= total;
                            samp_idx <= samp_idx + 7'h01;
                            cyc_cnt <= 9'h000;
                        end else if (tick) begin
                            cyc_cnt <= cyc_cnt + 9'h001;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rdata <= `ADCC_RESET_BYTE;
        end else if (ce) begin
            rdata <= `ADCC_RESET_BYTE;
            if (rd) begin
                case (addr)
                    `ADCC_OFS_GEN: rdata <= general_control;
                    `ADCC_OFS_ACC: rdata <= {5'h00, accumulation_control};
                    `ADCC_OFS_REFP: rdata <= reference_prescale_control;
                    `ADCC_OFS_DLY: rdata <= delay_control;
                    `ADCC_OFS_WMODE: rdata <= {5'h00, window_mode_control};
                    `ADCC_OFS_SLEN: rdata <= {3'h0, sample_length_control};
                    `ADCC_OFS_INSEL: rdata <= {3'h0, input_select};
                    `ADCC_OFS_CMD: rdata <= {7'h00, conversion_start};
                    `ADCC_OFS_EVT: rdata <= {7'h00, event_start_enable};
                    `ADCC_OFS_IEN: rdata <= {6'h00, interrupt_enable};
                    `ADCC_OFS_IFLG: rdata <= {6'h00, interrupt_flags};
                    `ADCC_OFS_DBG: rdata <= {7'h00, debug_keep_running};
                    `ADCC_OFS_SCR: rdata <= scratch_byte;
                    `ADCC_OFS_RES_L: rdata <= converted_value[7:0];
                    `ADCC_OFS_RES_H: rdata <= converted_value[15:8];
                    `ADCC_OFS_WLO_L: rdata <= window_low_threshold[7:0];
                    `ADCC_OFS_WLO_H: rdata <= window_low_threshold[15:8];
                    `ADCC_OFS_WHI_L: rdata <= window_high_threshold[7:0];
                    `ADCC_OFS_WHI_H: rdata <= window_high_threshold[15:8];
                    `ADCC_OFS_TRIM: rdata <= {7'h00, duty_cycle_trim};
                    default: rdata <= `ADCC_RESET_BYTE;
                endcase
            end
        end
    end

endmodule // adcc_ctrl

// ==== dv/adcc_ctrl_assertions.sv ====
// Assertion checker bound to the converter control block's ports.
`timescale 1ns/100ps
`include "adcc_defs.vh"

module adcc_checker (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [4:0] addr,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire result_ready_evt,
    input wire irq,
    input wire standby_sleep,
    input wire powerdown_sleep,
    input wire peripheral_clock_req,
    input wire sampling,
    input wire result_invalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    evt_single_pulse_a: assert property (
        ce && result_ready_evt |=> !result_ready_evt)
        else $error("result event longer than one clock");
    // The event may only follow a conversion that was really running.
    evt_after_conv_a: assert property (
        $rose(result_ready_evt) |-> $past(sampling) || $past(sampling, 2))
        else $error("result event without a conversion");
    rdata_idle_a: assert property (ce && !rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property (
        ce && rd && addr == 5'h07 |=> rdata == 8'h00)
        else $error("unmapped read returned data");
    irq_hold_a: assert property ($fell(irq) |-> $past(wr) &&
        ($past(addr) == `ADCC_OFS_IEN || $past(addr) == `ADCC_OFS_IFLG))
        else $error("interrupt dropped without a software write");
    clkreq_standby_a: assert property (
        peripheral_clock_req |-> standby_sleep)
        else $error("clock requested outside standby");
    // Once a conversion ends in standby the clock must be let go at once.
    clkreq_release_a: assert property (
        $fell(sampling) && standby_sleep |-> !peripheral_clock_req)
        else $error("clock still requested after the conversion");
    pd_freeze_a: assert property (
        powerdown_sleep [*3] |-> !result_ready_evt)
        else $error("conversion completed during power-down");
    invalid_update_a: assert property (
        $changed(result_invalid) |-> result_ready_evt)
        else $error("invalid marker changed without a completion");

    cover property (result_ready_evt);
    cover property (irq && wr && addr == `ADCC_OFS_IFLG);
    cover property (peripheral_clock_req && sampling);
endmodule // adcc_checker

bind adcc_ctrl adcc_checker u_chk (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wr(wr), .rd(rd), .rdata(rdata), .result_ready_evt(result_ready_evt),
    .irq(irq), .standby_sleep(standby_sleep), .sampling(sampling),
    .powerdown_sleep(powerdown_sleep), .result_invalid(result_invalid),
    .peripheral_clock_req(peripheral_clock_req));

// ==== dv/adcc_far_model.sv ====
// Model of the event router and analog core facing the converter control.
`timescale 1ns/100ps

module adcc_far_model (
    input wire clk,
    input wire rst,
    input wire fire,
    input wire sampling,
    input wire [9:0] level,
    output reg start_evt,
    output wire [9:0] sample_data
);
    reg hold;
    reg [9:0] churn;

    // Triggers are stretched over two clocks, so a design that starts on
    // the level instead of the rising edge shows a double start.
    always @(posedge clk) begin
        if (rst) begin
            hold <= 1'h0;
            start_evt <= 1'h0;
            churn <= 10'h000;
        end else begin
            hold <= fire;
            start_evt <= fire || hold;
            churn <= churn + 10'h13b;
        end
    end

    // Outside sampling the core output is garbage, never the last level.
    assign sample_data = sampling ? level : churn;
endmodule // adcc_far_model

// ==== dv/adc_event_irq_sleep_control_tb.sv ====
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`include "adcc_defs.vh"

module adc_event_irq_sleep_control_tb;
    reg clk = 1'h0;
    reg rst = 1'h1;
    reg [4:0] addr = 5'h00;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'h0, rd = 1'h0, fire = 1'h0;
    reg standby_sleep = 1'h0, powerdown_sleep = 1'h0;
    reg [9:0] level = 10'h155;
    reg req_seen = 1'h0;
    integer errors = 0, n_compared = 0;
    wire [7:0] rdata;
    wire [9:0] sample_data;
    wire start_evt, result_ready_evt, irq, peripheral_clock_req;
    wire sampling, result_invalid;
    wire [4:0] input_sel;
    wire [7:0] ref_prescale;
    wire trim_bit;

    adcc_ctrl uut (.clk(clk), .rst(rst), .ce(1'h1), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .start_evt(start_evt),
        .result_ready_evt(result_ready_evt), .irq(irq),
        .standby_sleep(standby_sleep), .powerdown_sleep(powerdown_sleep),
        .debug_halt(1'h0), .peripheral_clock_req(peripheral_clock_req),
        .sample_data(sample_data), .sampling(sampling),
        .input_sel(input_sel), .ref_prescale(ref_prescale),
        .trim_bit(trim_bit), .result_invalid(result_invalid));
    adcc_far_model far (.clk(clk), .rst(rst), .fire(fire), .sampling(sampling),
        .level(level), .start_evt(start_evt), .sample_data(sample_data));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task report_and_stop;
        begin
            $display("Compared %0d, mismatches %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask

    task wr_reg(input [4:0] a, input [7:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'h1;
            @(posedge clk);
            wr <= 1'h0;
            @(posedge clk);
        end
    endtask

    task rd_chk(input [4:0] a, input [7:0] exp);
        begin
            addr <= a;
            rd <= 1'h1;
            @(posedge clk);
            rd <= 1'h0;
            #1;
            chk(rdata, exp);
            @(posedge clk);
        end
    endtask

    task pulse_trigger;
        begin
            fire <= 1'h1;
            @(posedge clk);
            fire <= 1'h0;
        end
    endtask

    // A refused start is only visible as silence, so the bound matters.
    task wait_evt(input integer lim, input want);
        integer i;
        reg seen;
        begin
            seen = 1'h0;
            for (i = 0; i < lim && !seen; i = i + 1) begin
                @(posedge clk);
                #1;
                if (peripheral_clock_req === 1'h1) req_seen = 1'h1;
                if (result_ready_evt === 1'h1) seen = 1'h1;
            end
            @(posedge clk);
            if (want && !seen) begin
                errors = errors + 1;
                $display("[ERR] %0t: no result event in time", $time);
                report_and_stop;
            end else
                chk(seen, want);
        end
    endtask

    function win_exp(input integer m, input [9:0] v);
        begin
            win_exp = (m == 1 && v < 10'h080) || (m == 2 && v > 10'h200) ||
                (m == 3 && v > 10'h080 && v < 10'h200) ||
                (m == 4 && (v < 10'h080 || v > 10'h200));
        end
    endfunction

    task t_regs;
        begin
            rd_chk(`ADCC_OFS_GEN, 8'h00);
            wr_reg(`ADCC_OFS_SCR, 8'ha5);
            rd_chk(`ADCC_OFS_SCR, 8'ha5);
            rd_chk(5'h07, 8'h00);
            wr_reg(`ADCC_OFS_RES_L, 8'hff);
            rd_chk(`ADCC_OFS_RES_L, 8'h00);
            wr_reg(`ADCC_OFS_WLO_H, 8'h5a);
            rd_chk(`ADCC_OFS_WLO_H, 8'h5a);
            wr_reg(`ADCC_OFS_WLO_H, 8'h00);
            wr_reg(`ADCC_OFS_INSEL, 8'hff);
            rd_chk(`ADCC_OFS_INSEL, 8'h1f);
            chk(input_sel, 5'h1f);
            // Prescale field kept at zero so later timing is unchanged.
            wr_reg(`ADCC_OFS_REFP, 8'hf8);
            chk(ref_prescale, 8'h70);
            wr_reg(`ADCC_OFS_TRIM, 8'h01);
            chk(trim_bit, 1'h1);
        end
    endtask

    task t_single;
        begin
            wr_reg(`ADCC_OFS_GEN, 8'h01);
            wr_reg(`ADCC_OFS_IEN, 8'h01);
            wr_reg(`ADCC_OFS_CMD, 8'h01);
            wait_evt(200, 1'h1);
            rd_chk(`ADCC_OFS_CMD, 8'h00);
            rd_chk(`ADCC_OFS_IFLG, 8'h01);
            #1 chk(irq, 1'h1);
            rd_chk(`ADCC_OFS_RES_L, 8'h55);
            rd_chk(`ADCC_OFS_RES_H, 8'h01);
            wr_reg(`ADCC_OFS_IFLG, 8'h01);
            #1 chk(irq, 1'h0);
            rd_chk(`ADCC_OFS_IFLG, 8'h00);
            wr_reg(`ADCC_OFS_IEN, 8'h00);
        end
    endtask

    task t_event;
        begin
            wr_reg(`ADCC_OFS_EVT, 8'h01);
            pulse_trigger;
            repeat (3) @(posedge clk);
            rd_chk(`ADCC_OFS_CMD, 8'h01);
            #1 chk(sampling, 1'h1);
            wait_evt(200, 1'h1);
            wait_evt(60, 1'h0);
            wr_reg(`ADCC_OFS_EVT, 8'h00);
            wr_reg(`ADCC_OFS_IFLG, 8'h03);
        end
    endtask

    task t_window;
        integer m, j;
        begin
            wr_reg(`ADCC_OFS_WLO_L, 8'h80);
            wr_reg(`ADCC_OFS_WHI_H, 8'h02);
            for (j = 0; j < 3; j = j + 1) begin
                level <= (j == 0) ? 10'h040 : (j == 1) ? 10'h155 : 10'h300;
                for (m = 0; m < 5; m = m + 1) begin
                    wr_reg(`ADCC_OFS_WMODE, m[7:0]);
                    wr_reg(`ADCC_OFS_CMD, 8'h01);
                    wait_evt(200, 1'h1);
                    rd_chk(`ADCC_OFS_IFLG,
                        {6'h00, win_exp(m, level), 1'h1});
                    wr_reg(`ADCC_OFS_IFLG, 8'h03);
                end
            end
        end
    endtask

    task t_accum;
        begin
            level <= 10'h155;
            wr_reg(`ADCC_OFS_ACC, 8'h01);
            wr_reg(`ADCC_OFS_WMODE, 8'h04);
            wr_reg(`ADCC_OFS_CMD, 8'h01);
            wait_evt(300, 1'h1);
            wait_evt(60, 1'h0);
            rd_chk(`ADCC_OFS_IFLG, 8'h03);
            rd_chk(`ADCC_OFS_RES_L, 8'haa);
            rd_chk(`ADCC_OFS_RES_H, 8'h02);
            wr_reg(`ADCC_OFS_ACC, 8'h00);
            wr_reg(`ADCC_OFS_WMODE, 8'h00);
            wr_reg(`ADCC_OFS_IFLG, 8'h03);
        end
    endtask

    task t_cont;
        begin
            wr_reg(`ADCC_OFS_GEN, 8'h03);
            wr_reg(`ADCC_OFS_CMD, 8'h01);
            wait_evt(200, 1'h1);
            wait_evt(100, 1'h1);
            rd_chk(`ADCC_OFS_CMD, 8'h01);
            wr_reg(`ADCC_OFS_GEN, 8'h00);
            wr_reg(`ADCC_OFS_GEN, 8'h01);
            wait_evt(100, 1'h0);
            wr_reg(`ADCC_OFS_IFLG, 8'h03);
        end
    endtask

    task t_standby;
        begin
            standby_sleep <= 1'h1;
            wr_reg(`ADCC_OFS_CMD, 8'h01);
            wait_evt(150, 1'h0);
            #1 chk(peripheral_clock_req, 1'h0);
            wr_reg(`ADCC_OFS_GEN, 8'h00);
            wr_reg(`ADCC_OFS_DLY, 8'h20);
            wr_reg(`ADCC_OFS_IEN, 8'h01);
            wr_reg(`ADCC_OFS_GEN, 8'h81);
            wr_reg(`ADCC_OFS_EVT, 8'h01);
            req_seen = 1'h0;
            pulse_trigger;
            // Without the start-up delay the result would land in here.
            wait_evt(40, 1'h0);
            wait_evt(400, 1'h1);
            chk(req_seen, 1'h1);
            #1 chk(irq, 1'h1);
            repeat (4) @(posedge clk);
            #1 chk(peripheral_clock_req, 1'h0);
            standby_sleep <= 1'h0;
            wr_reg(`ADCC_OFS_EVT, 8'h00);
            wr_reg(`ADCC_OFS_IFLG, 8'h03);
            wr_reg(`ADCC_OFS_DLY, 8'h00);
            wr_reg(`ADCC_OFS_GEN, 8'h01);
        end
    endtask

    task t_powerdown;
        begin
            wr_reg(`ADCC_OFS_CMD, 8'h01);
            repeat (8) @(posedge clk);
            powerdown_sleep <= 1'h1;
            wait_evt(200, 1'h0);
            powerdown_sleep <= 1'h0;
            wait_evt(200, 1'h1);
            #1 chk(result_invalid, 1'h1);
            rd_chk(`ADCC_OFS_IFLG, 8'h01);
            wr_reg(`ADCC_OFS_IFLG, 8'h03);
            wr_reg(`ADCC_OFS_CMD, 8'h01);
            wait_evt(200, 1'h1);
            #1 chk(result_invalid, 1'h0);
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_regs;
        t_single;
        t_event;
        t_window;
        t_accum;
        t_cont;
        t_standby;
        t_powerdown;
        report_and_stop;
    end
endmodule // adc_event_irq_sleep_control_tb
